// >>> logic/ext_bus_pkg.sv
/*
 * Constants, types and register map of the external bus control block.
 * Assumes a single 250 MHz clock and a synchronous active high reset.
 */
// Behaviour
// [R1] Read select goes low in every external program, data or I/O read.
// [R2] Mode register bit 15 set makes the read pin carry inverted direction.
// [R3] The read pin function bit resets to zero, giving ordinary read select.
// [R4] Write enable falls as the data bus is driven; data valid at its rise.
// [R5] Write enable goes low in every external program, data or I/O write.
// [R6] Cycle strobe stays high except while an external bus cycle runs.
// [R7] Global request goes low when a global data-memory access starts.
// [R8] In hold, address, data and control float and hold grant goes low.
// [R9] Outside parties drive local bus lines only while hold is granted.
// [R10] A software-written latched flag drives the flag output pin.
// [R11] Conditional branch on the test input is taken when the input is low.
// [R12] Aux pins are set by the port control register and reset as inputs.
// [R13] Each aux pin is general purpose I/O or a serial port handshake line.
// [R14] Float control low puts all listed control and aux outputs in high-z.
// [R15] Zero wait-state memories are best read with inverted direction.
// [R16] Ready low makes the cycle wait a cycle and sample ready again.
// [R17] The direction output stays high and is low only during a write.
// [R18] Each space select is low only while its own space is accessed.
// [R19] Read select and write enable are never low in the same cycle.
package ext_bus_pkg;

    // ******************************************************************
    // Register map, word addresses of the software register port.
    // ******************************************************************
    localparam logic [7:0]  MODE_OFS      = 8'h00;
    localparam logic [7:0]  PORT_CTL_OFS  = 8'h01;
    localparam logic [7:0]  FLAG_OFS      = 8'h02;
    localparam logic [7:0]  STATUS_OFS    = 8'h03;

    // ******************************************************************
    // Field positions and reset values.
    // ******************************************************************
    localparam int          RD_FN_BIT     = 15;
    localparam logic        RD_FN_RST     = 1'b0;
    localparam int          DIR_LSB       = 0;
    localparam int          OUT_LSB       = 4;
    localparam int          HS_LSB        = 8;
    localparam logic [11:0] PORT_CTL_RST  = 12'h000;
    localparam logic        FLAG_RST      = 1'b0;
    localparam int          ST_HOLD_BIT   = 0;
    localparam int          ST_BUSY_BIT   = 1;
    localparam int          ST_TEST_BIT   = 2;
    localparam int          ST_AUX_LSB    = 4;

    // Cycle states, Gray coded along idle, access, idle and idle, hold.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_ACCESS = 2'h1,
        ST_HOLD   = 2'h2
    } bus_state_e;

    typedef enum logic [1:0] {
        SP_PROG = 2'h0,
        SP_DATA = 2'h1,
        SP_IO   = 2'h2
    } space_e;

    // One bus request from the core.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        global;
        space_e      space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_s;

    // Software register port request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_s;

endpackage

// >>> logic/ext_bus_ctrl.sv
/*
 * External parallel bus control: strobes, space selects, read pin
 * function, hold, global request, soft flag, branch test and aux pins.
 * Assumes all inputs are synchronous to ref_clk and the pad ring joins
 * each out/oe/in triple into one pin.
 */
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ext_bus_ctrl #(
    parameter int AUX_N = 4
) (
    // Clock and reset.
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Core bus request and answer.
    input  wire ext_bus_pkg::bus_req_s req,
    output logic                      req_ready,
    output logic                      rsp_valid,
    output logic [15:0]               rsp_data,
    // Software register port.
    input  wire ext_bus_pkg::reg_req_s reg_req,
    output logic [15:0]               reg_rdata,
    // Branch test.
    input  wire logic                 conditional_branch_op,
    input  wire logic                 branch_test_in_n,
    output logic                      branch_valid,
    output logic                      branch_taken,
    // Hold and float control.
    input  wire logic                 hold_req,
    input  wire logic                 float_n,
    // Serial port handshake lines.
    input  wire logic [AUX_N-1:0]     uart_hs_out,
    output logic [AUX_N-1:0]          uart_hs_in,
    // External bus pins.
    input  wire logic                 ready,
    output logic [15:0]               ext_addr,
    output logic                      ext_addr_oe,
    output logic [15:0]               ext_data_bus_out,
    output logic                      ext_data_bus_oe,
    input  wire logic [15:0]          ext_data_bus_in,
    output logic                      read_pin_n,
    output logic                      write_en_n,
    output logic                      cycle_strobe_n,
    output logic                      rw_dir,
    output logic                      program_space_sel_n,
    output logic                      data_space_sel_n,
    output logic                      io_space_sel_n,
    output logic                      mem_ctl_oe,
    output logic                      global_request_n,
    output logic                      hold_grant_n,
    output logic                      soft_flag_out,
    output logic                      misc_oe,
    output logic [AUX_N-1:0]          aux_io_pins_out,
    output logic [AUX_N-1:0]          aux_io_pins_oe,
    input  wire logic [AUX_N-1:0]     aux_io_pins_in
);

    if (AUX_N != 4) begin : g_bad_aux
        $error("ext_bus_ctrl: AUX_N must be 4 to fit the control register");
    end

    // ******************************************************************
    // State record.
    // ******************************************************************
    typedef struct packed {
        ext_bus_pkg::bus_state_e st;
        logic                    wr;
        ext_bus_pkg::space_e     space;
        logic                    rd_fn;
        logic [11:0]             port_ctl;
        logic                    flag;
        logic                    req_ready;
        logic                    rsp_valid;
        logic [15:0]             rsp_data;
        logic [15:0]             reg_rdata;
        logic                    tst_valid;
        logic                    tst_taken;
        logic [3:0]              hs_in;
        logic [15:0]             addr;
        logic [15:0]             dout;
        logic                    addr_oe;
        logic                    data_oe;
        logic                    read_n;
        logic                    we_n;
        logic                    cyc_n;
        logic                    rw;
        logic                    pgm_n;
        logic                    dat_n;
        logic                    io_n;
        logic                    ctl_oe;
        logic                    greq_n;
        logic                    grant_n;
        logic                    misc_oe;
        logic [3:0]              aux_out;
        logic [3:0]              aux_oe;
    } state_s;

    state_s s_ff;
    state_s nxt_s;

    // Reads of the status word gather live state; mapped words only.
    function automatic logic [15:0] read_word(input state_s s,
                                              input logic [7:0] a,
                                              input logic test_n,
                                              input logic [3:0] aux);
        logic [15:0] w;
        w = 16'h0000;
        case (a)
            ext_bus_pkg::MODE_OFS:     w[ext_bus_pkg::RD_FN_BIT] = s.rd_fn;
            ext_bus_pkg::PORT_CTL_OFS: w[11:0] = s.port_ctl;
            ext_bus_pkg::FLAG_OFS:     w[0] = s.flag;
            ext_bus_pkg::STATUS_OFS: begin
                w[ext_bus_pkg::ST_HOLD_BIT] = (s.st == ext_bus_pkg::ST_HOLD);
                w[ext_bus_pkg::ST_BUSY_BIT] =
                    (s.st == ext_bus_pkg::ST_ACCESS);
                w[ext_bus_pkg::ST_TEST_BIT] = test_n;
                w[ext_bus_pkg::ST_AUX_LSB +: 4] = aux;
            end
            default:                   w = 16'h0000;
        endcase
        return w;
    endfunction

    // ******************************************************************
    // Next state.
    // ******************************************************************
    // Pin levels are computed for the coming cycle so every pin is a flop.
    always_comb begin
        logic [3:0] dir;
        logic [3:0] hs;
        logic       fl;
        dir = 4'h0;
        hs = 4'h0;
        fl = ~float_n;
        nxt_s = s_ff;
        nxt_s.rsp_valid = 1'b0;
        nxt_s.tst_valid = 1'b0;
        nxt_s.reg_rdata = 16'h0000;
        if (reg_req.rd) begin
            nxt_s.reg_rdata = read_word(s_ff, reg_req.addr,
                                        branch_test_in_n, aux_io_pins_in);
        end
        if (reg_req.wr) begin
            case (reg_req.addr)
                ext_bus_pkg::MODE_OFS:
                    nxt_s.rd_fn = reg_req.wdata[ext_bus_pkg::RD_FN_BIT]; // R2
                ext_bus_pkg::PORT_CTL_OFS:
                    nxt_s.port_ctl = reg_req.wdata[11:0]; // R12
                ext_bus_pkg::FLAG_OFS:
                    nxt_s.flag = reg_req.wdata[0]; // R10
                default: ;
            endcase
        end
        // Test input is sampled in the op cycle; low means branch.
        if (conditional_branch_op) begin
            nxt_s.tst_valid = 1'b1;
            nxt_s.tst_taken = ~branch_test_in_n; // R11
        end
        // A request offered with req_ready high wins over a hold in that cycle,
        // so an accepted access is never lost.
        case (s_ff.st)
            ext_bus_pkg::ST_IDLE: begin
                if (req.valid && s_ff.req_ready) begin
                    nxt_s.st = ext_bus_pkg::ST_ACCESS;
                    nxt_s.wr = req.write;
                    nxt_s.space = req.space;
                    nxt_s.addr = req.addr;
                    nxt_s.dout = req.wdata;
                    nxt_s.greq_n = ~(req.global &&
                                     req.space == ext_bus_pkg::SP_DATA); // R7
                end else if (hold_req) begin
                    nxt_s.st = ext_bus_pkg::ST_HOLD;
                end
            end
            ext_bus_pkg::ST_ACCESS: begin
                // Ready low holds the cycle; it is sampled again next edge.
                if (ready) begin // R16
                    nxt_s.st = ext_bus_pkg::ST_IDLE;
                    nxt_s.rsp_valid = 1'b1;
                    nxt_s.rsp_data = s_ff.wr ? 16'h0000 : ext_data_bus_in;
                    nxt_s.greq_n = 1'b1;
                end
            end
            ext_bus_pkg::ST_HOLD: begin
                if (!hold_req) begin
                    nxt_s.st = ext_bus_pkg::ST_IDLE;
                end
            end
            default: nxt_s.st = ext_bus_pkg::ST_IDLE;
        endcase
        nxt_s.req_ready = (nxt_s.st == ext_bus_pkg::ST_IDLE);
        // Control strobes follow the coming state.
        nxt_s.cyc_n = (nxt_s.st != ext_bus_pkg::ST_ACCESS); // R6
        nxt_s.we_n = nxt_s.cyc_n | ~nxt_s.wr; // R5 R19
        nxt_s.rw = ~(~nxt_s.cyc_n & nxt_s.wr); // R17
        nxt_s.pgm_n = nxt_s.cyc_n |
                      (nxt_s.space != ext_bus_pkg::SP_PROG); // R18
        nxt_s.dat_n = nxt_s.cyc_n | (nxt_s.space != ext_bus_pkg::SP_DATA);
        nxt_s.io_n = nxt_s.cyc_n | (nxt_s.space != ext_bus_pkg::SP_IO);
        // Inverted direction is low for reads, so it never meets a write.
        nxt_s.read_n = nxt_s.rd_fn ? ~nxt_s.rw // R2 R15
                                   : (nxt_s.cyc_n | nxt_s.wr); // R1 R19
        nxt_s.grant_n = (nxt_s.st != ext_bus_pkg::ST_HOLD); // R8
        // Float control gates every listed output; hold floats the bus.
        nxt_s.misc_oe = ~fl; // R14
        nxt_s.ctl_oe = ~fl & nxt_s.grant_n; // R8 R14
        nxt_s.addr_oe = nxt_s.ctl_oe;
        nxt_s.data_oe = nxt_s.ctl_oe & ~nxt_s.we_n; // R4
        // Aux pins: direction bit set drives, handshake picks the source.
        dir = nxt_s.port_ctl[ext_bus_pkg::DIR_LSB +: 4];
        hs = nxt_s.port_ctl[ext_bus_pkg::HS_LSB +: 4];
        nxt_s.aux_oe = dir & {4{~fl}}; // R12 R14
        nxt_s.aux_out = (hs & uart_hs_out) |
                        (~hs & nxt_s.port_ctl[ext_bus_pkg::OUT_LSB +: 4]); // R13
        nxt_s.hs_in = hs & ~dir & aux_io_pins_in; // R13
    end

    // ******************************************************************
    // State register.
    // ******************************************************************
    // Reset leaves the bus idle, the read pin ordinary and aux as inputs.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_ff <= '{st: ext_bus_pkg::ST_IDLE, space: ext_bus_pkg::SP_PROG,
                      rd_fn: ext_bus_pkg::RD_FN_RST, // R3
                      port_ctl: ext_bus_pkg::PORT_CTL_RST, // R12
                      flag: ext_bus_pkg::FLAG_RST,
                      read_n: 1'b1, we_n: 1'b1, cyc_n: 1'b1, rw: 1'b1,
                      pgm_n: 1'b1, dat_n: 1'b1, io_n: 1'b1, greq_n: 1'b1,
                      grant_n: 1'b1, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Pins and answers straight from the state flops.
    assign req_ready           = s_ff.req_ready;
    assign rsp_valid           = s_ff.rsp_valid;
    assign rsp_data            = s_ff.rsp_data;
    assign reg_rdata           = s_ff.reg_rdata;
    assign branch_valid        = s_ff.tst_valid;
    assign branch_taken        = s_ff.tst_taken;
    assign uart_hs_in          = s_ff.hs_in;
    assign ext_addr            = s_ff.addr;
    assign ext_addr_oe         = s_ff.addr_oe;
    assign ext_data_bus_out    = s_ff.dout;
    assign ext_data_bus_oe     = s_ff.data_oe;
    assign read_pin_n          = s_ff.read_n;
    assign write_en_n          = s_ff.we_n;
    assign cycle_strobe_n      = s_ff.cyc_n;
    assign rw_dir              = s_ff.rw;
    assign program_space_sel_n = s_ff.pgm_n;
    assign data_space_sel_n    = s_ff.dat_n;
    assign io_space_sel_n      = s_ff.io_n;
    assign mem_ctl_oe          = s_ff.ctl_oe;
    assign global_request_n    = s_ff.greq_n;
    assign hold_grant_n        = s_ff.grant_n;
    assign soft_flag_out       = s_ff.flag;
    assign misc_oe             = s_ff.misc_oe;
    assign aux_io_pins_out     = s_ff.aux_out;
    assign aux_io_pins_oe      = s_ff.aux_oe;

    // ******************************************************************
    // Checks.
    // ******************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    read_sel_a: assert property (s_ff.st == ext_bus_pkg::ST_ACCESS && // R1
        !s_ff.wr && !s_ff.rd_fn |-> !read_pin_n)
        else $error("read select not low in read cycle");
    read_fn_a: assert property (s_ff.rd_fn |-> read_pin_n == ~rw_dir) // R2
        else $error("read pin not inverted direction");
    reset_fn_a: assert property ($past(rst) |-> !s_ff.rd_fn) // R3
        else $error("read pin function not cleared by reset");
    we_data_a: assert property ($fell(write_en_n) |-> ext_data_bus_oe // R4
        || !mem_ctl_oe)
        else $error("write enable fell without data drive");
    write_we_a: assert property (req.valid && req_ready && req.write // R5
        |=> !write_en_n && !cycle_strobe_n)
        else $error("write enable missing in write");
    strobe_a: assert property (cycle_strobe_n == // R6
        (s_ff.st != ext_bus_pkg::ST_ACCESS))
        else $error("strobe not matching bus cycle");
    global_req_a: assert property (req.valid && req_ready && req.global // R7
        && req.space == ext_bus_pkg::SP_DATA |=> !global_request_n)
        else $error("global request missing");
    hold_float_a: assert property (s_ff.st == ext_bus_pkg::ST_HOLD |-> // R8
        !hold_grant_n && !mem_ctl_oe && !ext_addr_oe && !ext_data_bus_oe)
        else $error("hold without float and grant");
    flag_write_a: assert property (reg_req.wr && // R10
        reg_req.addr == ext_bus_pkg::FLAG_OFS
        |=> soft_flag_out == $past(reg_req.wdata[0]))
        else $error("flag output not written");
    branch_test_a: assert property (conditional_branch_op |=> // R11
        branch_valid && branch_taken == !$past(branch_test_in_n))
        else $error("branch decision wrong");
    aux_reset_a: assert property ($past(rst) |-> aux_io_pins_oe == 4'h0) // R12
        else $error("aux pins not inputs after reset");
    float_off_a: assert property (!float_n |=> !misc_oe && !mem_ctl_oe // R14
        && aux_io_pins_oe == 4'h0)
        else $error("outputs not floated");
    ready_wait_a: assert property (s_ff.st == ext_bus_pkg::ST_ACCESS && // R16
        !ready |=> s_ff.st == ext_bus_pkg::ST_ACCESS && !cycle_strobe_n)
        else $error("cycle ended while not ready");
    dir_write_a: assert property (!rw_dir |-> // R17
        s_ff.st == ext_bus_pkg::ST_ACCESS && s_ff.wr)
        else $error("direction low outside write");
    space_sel_a: assert property (!program_space_sel_n |-> // R18
        !cycle_strobe_n && s_ff.space == ext_bus_pkg::SP_PROG)
        else $error("program select outside its access");
    dir_excl_a: assert property (!(!write_en_n && !read_pin_n)) // R19
        else $error("read and write active together");

endmodule
`default_nettype wire

// >>> test/ext_bus_mem_model.sv
/*
 * Behavioural external memory that answers the bus control block.
 * Assumes one clock shared with the block and resolved pin levels.
 */
`timescale 1ns/10ps
`default_nettype none
module ext_bus_mem_model (
    // Clock, reset and wait setting.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [2:0]  wait_cycles,
    // Bus pins seen from the memory side.
    input  wire logic [15:0] ext_addr,
    input  wire logic [15:0] ext_data_bus_out,
    input  wire logic        write_en_n,
    input  wire logic        cycle_strobe_n,
    input  wire logic        rw_dir,
    output logic             ready,
    output logic [15:0]      ext_data_bus_in
);
    logic [15:0] mem_ff [16];
    logic [15:0] cap_addr_ff;
    logic [15:0] cap_data_ff;
    logic [15:0] last_ff;
    logic        we_prev_ff;
    logic [2:0]  wait_cnt_ff;
    logic        drive;

    // Strobe low with direction high reads; no read pin decoding needed.
    // The model only answers and never drives address or control lines.
    assign drive = !cycle_strobe_n && rw_dir;
    // A released line shows the inverse of its last value, never a copy.
    assign ext_data_bus_in = drive ? mem_ff[ext_addr[3:0]] : ~last_ff;
    // Ready stays low for the set number of strobe cycles.
    assign ready = (wait_cnt_ff >= wait_cycles);

    // Write data is committed on the rising edge of write enable.
    always_ff @(posedge ref_clk) begin
        last_ff <= ext_data_bus_in;
        we_prev_ff <= rst ? 1'b1 : write_en_n;
        wait_cnt_ff <= (rst || cycle_strobe_n) ? 3'h0 : wait_cnt_ff + 3'h1;
        if (!write_en_n) begin
            cap_addr_ff <= ext_addr;
            cap_data_ff <= ext_data_bus_out;
        end
        if (!we_prev_ff && write_en_n) begin
            mem_ff[cap_addr_ff[3:0]] <= cap_data_ff;
        end
    end
endmodule
`default_nettype wire

// >>> test/testbench.sv
/*
 * Self-checking bench for the external bus control block.
 * Assumes the memory model answers every access on the shared clock.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                  ref_clk, rst, conditional_branch_op;
    logic                  branch_test_in_n, hold_req, float_n, ready;
    ext_bus_pkg::bus_req_s req;
    ext_bus_pkg::reg_req_s reg_req;
    logic [3:0]            uart_hs_out, uart_hs_in, aux_io_pins_in;
    logic [3:0]            aux_io_pins_out, aux_io_pins_oe;
    logic [15:0]           rsp_data, reg_rdata, ext_addr, q;
    logic [15:0]           ext_data_bus_out, ext_data_bus_in;
    logic                  req_ready, rsp_valid, branch_valid, branch_taken;
    logic                  ext_addr_oe, ext_data_bus_oe, read_pin_n;
    logic                  write_en_n, cycle_strobe_n, rw_dir, mem_ctl_oe;
    logic                  program_space_sel_n, data_space_sel_n;
    logic                  io_space_sel_n, global_request_n, hold_grant_n;
    logic                  soft_flag_out, misc_oe, rd_fn;
    logic [2:0]            wait_cycles;
    int                    mismatches, n_tests, cyc;

    ext_bus_ctrl ext_bus_ctrl_i (.ref_clk, .rst, .req, .req_ready,
        .rsp_valid, .rsp_data, .reg_req, .reg_rdata, .conditional_branch_op,
        .branch_test_in_n, .branch_valid, .branch_taken, .hold_req, .float_n,
        .uart_hs_out, .uart_hs_in, .ready, .ext_addr, .ext_addr_oe,
        .ext_data_bus_out, .ext_data_bus_oe, .ext_data_bus_in, .read_pin_n,
        .write_en_n, .cycle_strobe_n, .rw_dir, .program_space_sel_n,
        .data_space_sel_n, .io_space_sel_n, .mem_ctl_oe, .global_request_n,
        .hold_grant_n, .soft_flag_out, .misc_oe, .aux_io_pins_out,
        .aux_io_pins_oe, .aux_io_pins_in);
    ext_bus_mem_model ext_bus_mem_model_i (.ref_clk, .rst, .wait_cycles,
        .ext_addr, .ext_data_bus_out, .write_en_n, .cycle_strobe_n, .rw_dir,
        .ready, .ext_data_bus_in);

    // Compare one value and count it; unknowns never match.
    task automatic chk(input string name, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Register port cycles; read data is taken in the cycle after the strobe.
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        reg_req <= '0;
        #1 d = reg_rdata;
    endtask

    // One core access; the request is held until an edge sees req_ready high.
    task automatic acc(input logic w, g, input int sp,
                       input logic [15:0] a, d, input int waits,
                       output logic [15:0] rd);
        int         n;
        logic [2:0] e;
        e = ~(3'b100 >> sp);
        @(posedge ref_clk);
        req <= '{valid: 1'b1, write: w, global: g,
                 space: ext_bus_pkg::space_e'(sp), addr: a, wdata: d};
        n = 0;
        do begin @(posedge ref_clk); n++; end
        while (req_ready !== 1'b1 && n < 20);
        req <= '0;
        #1;
        chk("strobe_busy", cycle_strobe_n, 0);
        chk("write_en", write_en_n, !w);
        chk("read_pin", read_pin_n, w);
        chk("direction", rw_dir, !w);
        chk("space_sel", {program_space_sel_n, data_space_sel_n,
            io_space_sel_n}, e);
        chk("global_req", global_request_n, !(g && sp == 1));
        chk("data_oe", ext_data_bus_oe, w);
        if (w) chk("data_out", ext_data_bus_out, d);
        chk("address", ext_addr, a);
        n = 0;
        do begin @(posedge ref_clk); #1; n++; end
        while (rsp_valid !== 1'b1 && n < 20);
        chk("latency", n, 1 + waits);
        chk("strobe_idle", cycle_strobe_n, 1);
        chk("read_pin_idle", read_pin_n, !rd_fn);
        rd = rsp_data;
    endtask

    // Free-running clock.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    // Main sequence of scenarios.
    initial begin
        rst = 1'b1; req = '0; reg_req = '0; conditional_branch_op = 1'b0;
        branch_test_in_n = 1'b1; hold_req = 1'b0; float_n = 1'b1;
        uart_hs_out = 4'h6; aux_io_pins_in = 4'h5; wait_cycles = 3'h0;
        rd_fn = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("rst_strobe", cycle_strobe_n, 1);
        chk("rst_read_pin", read_pin_n, 1);
        chk("rst_grant", hold_grant_n, 1);
        chk("rst_aux_oe", aux_io_pins_oe, 0);
        chk("rst_flag", soft_flag_out, 0);
        chk("rst_oe", {mem_ctl_oe, misc_oe}, 2'b11);
        reg_rd(ext_bus_pkg::MODE_OFS, q);
        chk("rst_mode", q, 16'h0000);
        // Writes then reads in every space, back to back.
        for (int i = 0; i < 3; i++) acc(1, 0, i, i, 16'ha5c0 + i, 0, q);
        for (int i = 0; i < 3; i++) begin
            acc(0, 0, i, i, 16'h0000, 0, q);
            chk("read_data", q, 16'ha5c0 + i);
        end
        // Two wait cycles stretch the read.
        @(posedge ref_clk) wait_cycles <= 3'h2;
        acc(0, 0, 1, 16'h0001, 16'h0000, 2, q);
        chk("wait_data", q, 16'ha5c1);
        @(posedge ref_clk) wait_cycles <= 3'h0;
        // Global request only in data space.
        acc(1, 1, 1, 16'h0003, 16'h1234, 0, q);
        acc(1, 1, 0, 16'h0004, 16'h4321, 0, q);
        // Read pin carries inverted direction when the mode bit is set.
        reg_wr(ext_bus_pkg::MODE_OFS, 16'h8000);
        rd_fn = 1'b1;
        reg_rd(ext_bus_pkg::MODE_OFS, q);
        chk("mode_bit", q, 16'h8000);
        acc(0, 0, 1, 16'h0003, 16'h0000, 0, q);
        chk("read_pin_function_sel_data", q, 16'h1234);
        acc(1, 0, 2, 16'h0005, 16'h0bad, 0, q);
        reg_wr(ext_bus_pkg::MODE_OFS, 16'h0000);
        rd_fn = 1'b0;
        // Flag set and cleared.
        for (int f = 1; f >= 0; f--) begin
            reg_wr(ext_bus_pkg::FLAG_OFS, 16'(f));
            reg_rd(ext_bus_pkg::FLAG_OFS, q);
            chk("flag_reg", q[0], f);
            chk("flag_pin", soft_flag_out, f);
        end
        // Branch taken on a low test input only.
        for (int b = 0; b < 2; b++) begin
            @(posedge ref_clk);
            conditional_branch_op <= 1'b1;
            branch_test_in_n <= b[0];
            @(posedge ref_clk);
            conditional_branch_op <= 1'b0;
            #1;
            chk("branch", {branch_valid, branch_taken}, {1'b1, !b[0]});
        end
        // Aux pins as outputs, as handshake lines, then as inputs.
        reg_wr(ext_bus_pkg::PORT_CTL_OFS, 16'h00af);
        reg_rd(ext_bus_pkg::PORT_CTL_OFS, q);
        chk("aux_ctl", q, 16'h00af);
        chk("aux_gpio", {aux_io_pins_oe, aux_io_pins_out}, 8'hfa);
        reg_wr(ext_bus_pkg::PORT_CTL_OFS, 16'h0f0f);
        reg_rd(ext_bus_pkg::PORT_CTL_OFS, q);
        chk("aux_hs", aux_io_pins_out, 4'h6);
        reg_wr(ext_bus_pkg::PORT_CTL_OFS, 16'h0f00);
        reg_rd(ext_bus_pkg::STATUS_OFS, q);
        chk("aux_in", {aux_io_pins_oe, q[7:4], uart_hs_in}, 12'h055);
        // Float control removes every listed driver.
        reg_wr(ext_bus_pkg::PORT_CTL_OFS, 16'h000f);
        @(posedge ref_clk) float_n <= 1'b0;
        #9 chk("float", {mem_ctl_oe, misc_oe, aux_io_pins_oe}, 0);
        @(posedge ref_clk) float_n <= 1'b1;
        #9 chk("unfloat", {mem_ctl_oe, misc_oe}, 2'b11);
        // Hold floats the bus and reports it.
        @(posedge ref_clk) hold_req <= 1'b1;
        #13 chk("hold", {hold_grant_n, mem_ctl_oe, ext_addr_oe,
            ext_data_bus_oe, misc_oe}, 5'b00001);
        reg_rd(ext_bus_pkg::STATUS_OFS, q);
        chk("hold_status", q[0], 1);
        @(posedge ref_clk) hold_req <= 1'b0;
        #13 chk("unhold", {hold_grant_n, mem_ctl_oe}, 2'b11);
        // Unmapped reads give zero.
        reg_rd(8'h07, q);
        chk("unmapped", q, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
